//--- hw/ecr_regs.vh
// Register map, field positions and codes of the exception cause and return block
`ifndef ECR_REGS_VH
`define ECR_REGS_VH

// Word offsets (byte addresses) on the register bus
`define ECR_OFS_CAUSE 8'h00
`define ECR_OFS_RET_LO 8'h04
`define ECR_OFS_RET_HI 8'h08
`define ECR_OFS_PROC_ID 8'h0C
`define ECR_OFS_STATUS 8'h10
`define ECR_OFS_COUNT 8'h14
`define ECR_OFS_COMPARE 8'h18

// Cause register fields
`define ECR_CAUSE_DS_BIT 31
`define ECR_CAUSE_CE_HI 29
`define ECR_CAUSE_CE_LO 28
`define ECR_CAUSE_HWIP_HI 15
`define ECR_CAUSE_HWIP_LO 10
`define ECR_CAUSE_SWIP_HI 9
`define ECR_CAUSE_SWIP_LO 8
`define ECR_CAUSE_TIMER_BIT 15
`define ECR_CAUSE_CODE_HI 6
`define ECR_CAUSE_CODE_LO 2

// Status register field
`define ECR_STATUS_EXL_BIT 1

// Identification fields
`define ECR_ID_IMP_HI 15
`define ECR_ID_IMP_LO 8
`define ECR_ID_REV_HI 7
`define ECR_ID_REV_LO 0

// Exception codes
`define ECR_EXC_INTERRUPT 5'h00
`define ECR_EXC_TLB_MODIFY 5'h01
`define ECR_EXC_TLB_MISS_LOAD 5'h02
`define ECR_EXC_TLB_MISS_STORE 5'h03
`define ECR_EXC_ADDR_ERR_LOAD 5'h04
`define ECR_EXC_ADDR_ERR_STORE 5'h05
`define ECR_EXC_FETCH_BUS_ERR 5'h06
`define ECR_EXC_DATA_BUS_ERR 5'h07
`define ECR_EXC_SYSCALL 5'h08
`define ECR_EXC_BREAKPOINT 5'h09
`define ECR_EXC_RESERVED_INSN 5'h0A
`define ECR_EXC_COP_UNUSABLE 5'h0B
`define ECR_EXC_OVERFLOW 5'h0C
`define ECR_EXC_TRAP 5'h0D
`define ECR_EXC_FLOAT 5'h0F

// Reset values
`define ECR_ZERO32 32'h00000000
`define ECR_ZERO64 64'h0000000000000000

`endif

//--- hw/ecr_code_filter.v
// Exception code filter: passes documented codes, maps reserved ones to reserved-instruction
`timescale 1ns/1ns
`default_nettype none
`include "ecr_regs.vh"

module ecr_code_filter
(
  input wire [4:0] code_i,
  output reg [4:0] code_o
);

  // Codes 14 and 16..31 are never produced; stray requests fold to a legal code
  always @*
  begin
    case (code_i)
      `ECR_EXC_INTERRUPT, `ECR_EXC_TLB_MODIFY, `ECR_EXC_TLB_MISS_LOAD,
      `ECR_EXC_TLB_MISS_STORE: code_o = code_i;
      `ECR_EXC_ADDR_ERR_LOAD, `ECR_EXC_ADDR_ERR_STORE, `ECR_EXC_FETCH_BUS_ERR,
      `ECR_EXC_DATA_BUS_ERR: code_o = code_i;
      `ECR_EXC_SYSCALL, `ECR_EXC_BREAKPOINT, `ECR_EXC_RESERVED_INSN,
      `ECR_EXC_COP_UNUSABLE: code_o = code_i;
      `ECR_EXC_OVERFLOW, `ECR_EXC_TRAP, `ECR_EXC_FLOAT: code_o = code_i;
      default: code_o = `ECR_EXC_RESERVED_INSN;
    endcase
  end

endmodule // ecr_code_filter

`default_nettype wire

//--- hw/ecr_exception_regs.v
// Exception cause, return address and identification registers with Wishbone slave
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ecr_regs.vh"

// Contract
// - Software writes only cause bits 9..8; all other cause fields ignore writes.
// - On exception, cause bit 31 shows whether the instruction sat in a delay slot.
// - Coprocessor unusable exception records the two-bit coprocessor number in bits 29..28.
// - Cause bits 15..10 mirror the six pending hardware interrupt inputs.
// - Codes 0..3: interrupt, translation modify, translation miss load, miss store.
// - Codes 4..7: address error load/store, fetch bus error, data bus error.
// - Codes 8..11: syscall, breakpoint, reserved instruction, coprocessor unusable.
// - Codes 12, 13, 15: overflow, trap, float; 14 and 16..31 never produced.
// - Return address register is software readable and writable.
// - Outside delay slot, return register takes the faulting instruction address.
// - In delay slot, return register takes the branch address and flag sets.
// - Return register is not loaded by an exception while the exception-level flag is set.
// - Return register is 32 or 64 bits wide by mode; no reset value.
// - Identification is read-only: implementation bits 15..8, revision bits 7..0.
// - Identification bits 31..16 read zero; writes do nothing.
// - Count equal to compare sets timer pending bit 15 of the cause.
// - Exception-level flag is status bit 1; one means exception level.
// - Writing compare clears the timer pending indication.
module ecr_exception_regs
#(
  parameter [7:0] IMP_NUMBER = 8'h5A, // Arbitrary value
  parameter [7:0] REV_NUMBER = 8'h01  // Arbitrary value
)
(
  input wire sys_clk_i,
  input wire rstn_i,
  input wire clk_en_i,
  // Wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  output wire wb_err_o,
  // Pipeline exception commit
  input wire exc_take_i,
  input wire [4:0] exc_code_i,
  input wire exc_delay_slot_i,
  input wire [1:0] exc_cop_num_i,
  input wire [63:0] exc_insn_addr_i,
  input wire [63:0] exc_branch_addr_i,
  input wire mode64_i,
  // Interrupt inputs
  input wire [5:0] hw_int_i,
  // Register views for the pipeline
  output reg [31:0] cause_o,
  output reg [63:0] return_address_o,
  output reg exception_level_flag_o,
  output reg [1:0] sw_int_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Register map seen by software, all 32-bit words on byte offsets:
  //   cause, return address low, return address high, identification,
  //   status (exception-level flag only), free-running count, compare.
  // Only the fields this block owns are kept; other status fields are
  // left to their own blocks and read back as zero here.
  //
  // Exception fields in the cause word move only when the pipeline
  // commits an exception, all in the same cycle, so a handler never
  // sees a code from one exception beside a slot flag from another.
  //
  // The return register carries no reset on purpose: it is undefined
  // after cold reset, and leaving out the reset saves 64 reset paths.
  // Software must not rely on its value before the first exception or
  // the first write.
  //
  // The timer pending bit is set by a count match and cleared only by
  // a compare write; a match in the same cycle as that write wins, so
  // an interrupt is never lost to a late reprogramming.
  //
  // The clock enable freezes everything, the bus acknowledge included;
  // a master that sees no answer while it is low simply keeps waiting.
  //
  // Interrupt inputs are taken as synchronous to the clock and are
  // registered once, so pending bits trail the pins by one cycle.
  reg mapped_q;
  reg hw_int5_q;
  reg delay_slot_flag_reg;
  reg [1:0] cop_num_reg;
  reg [1:0] sw_int_reg;
  reg [4:0] exception_code_reg;
  reg timer_pending_reg;
  reg [4:0] hw_pending_reg;
  reg [63:0] return_address_reg;
  reg exl_reg;
  reg [31:0] count_reg;
  reg [31:0] compare_reg;
  reg ack_reg;
  wire [4:0] code_legal;
  wire [31:0] cause_view;
  wire [31:0] id_view;
  wire [31:0] wmask;
  wire bus_req;
  wire wr_stb;
  wire mapped;
  wire wr_cause;
  wire wr_ret_lo;
  wire wr_ret_hi;
  wire wr_status;
  wire wr_count;
  wire wr_compare;
  wire timer_hit;

  // ----------------------------------------------------------------
  // Exception code filter
  // ----------------------------------------------------------------
  ecr_code_filter u_code_filter
  (
    .code_i(exc_code_i),
    .code_o(code_legal)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One wait state: ack rises the cycle after the request and drops after one cycle
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign mapped = (wb_adr_i == `ECR_OFS_CAUSE) | (wb_adr_i == `ECR_OFS_RET_LO) |
                  (wb_adr_i == `ECR_OFS_RET_HI) | (wb_adr_i == `ECR_OFS_PROC_ID) |
                  (wb_adr_i == `ECR_OFS_STATUS) | (wb_adr_i == `ECR_OFS_COUNT) |
                  (wb_adr_i == `ECR_OFS_COMPARE);
  assign wb_ack_o = ack_reg & wb_cyc_i & wb_stb_i & mapped_q;
  assign wb_err_o = ack_reg & wb_cyc_i & wb_stb_i & ~mapped_q;
  // Writes commit on the acknowledging edge, as the master samples ack there
  assign wr_stb = ack_reg & wb_cyc_i & wb_stb_i & wb_we_i & clk_en_i;
  assign wr_cause = wr_stb & (wb_adr_i == `ECR_OFS_CAUSE);
  assign wr_ret_lo = wr_stb & (wb_adr_i == `ECR_OFS_RET_LO);
  assign wr_ret_hi = wr_stb & (wb_adr_i == `ECR_OFS_RET_HI);
  assign wr_status = wr_stb & (wb_adr_i == `ECR_OFS_STATUS);
  assign wr_count = wr_stb & (wb_adr_i == `ECR_OFS_COUNT);
  assign wr_compare = wr_stb & (wb_adr_i == `ECR_OFS_COMPARE);
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Acknowledge generator
  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ack_reg <= 1'b0;
      mapped_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      ack_reg <= bus_req;
      mapped_q <= mapped;
    end
  end

  // ----------------------------------------------------------------
  // Cause register
  // ----------------------------------------------------------------
  assign timer_hit = (count_reg == compare_reg);

  // Exception fields change only on a committed exception; writes hit soft bits only
  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      delay_slot_flag_reg <= 1'b0;
      cop_num_reg <= 2'h0;
      sw_int_reg <= 2'h0;
      exception_code_reg <= `ECR_EXC_INTERRUPT;
      hw_pending_reg <= 5'h00;
      timer_pending_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (exc_take_i)
      begin
        exception_code_reg <= code_legal;
        delay_slot_flag_reg <= exc_delay_slot_i;
        if (code_legal == `ECR_EXC_COP_UNUSABLE)
          cop_num_reg <= exc_cop_num_i;
      end
      if (wr_cause && wb_sel_i[1])
        sw_int_reg <= wb_dat_i[`ECR_CAUSE_SWIP_HI:`ECR_CAUSE_SWIP_LO];
      hw_pending_reg <= hw_int_i[4:0];
      // Compare hit wins over the clear from a compare write in the same cycle
      if (timer_hit)
        timer_pending_reg <= 1'b1;
      else if (wr_compare)
        timer_pending_reg <= 1'b0;
    end
  end

  // Top pending bit shares the hardware interrupt input five with the timer
  assign cause_view = {delay_slot_flag_reg, 1'b0, cop_num_reg, 12'h000,
                       hw_int5_q | timer_pending_reg, hw_pending_reg, sw_int_reg,
                       1'b0, exception_code_reg, 2'b00};

  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      hw_int5_q <= 1'b0;
    else if (clk_en_i)
      hw_int5_q <= hw_int_i[5];
  end

  // ----------------------------------------------------------------
  // Return address and status flag
  // ----------------------------------------------------------------
  // Return register has no reset: its content is undefined after cold reset
  always @(posedge sys_clk_i)
  begin
    if (clk_en_i)
    begin
      if (exc_take_i && !exl_reg)
      begin
        if (exc_delay_slot_i)
          return_address_reg <= exc_branch_addr_i;
        else
          return_address_reg <= exc_insn_addr_i;
      end
      else
      begin
        if (wr_ret_lo)
          return_address_reg[31:0] <= (return_address_reg[31:0] & ~wmask) |
                                      (wb_dat_i & wmask);
        if (wr_ret_hi && mode64_i)
          return_address_reg[63:32] <= (return_address_reg[63:32] & ~wmask) |
                                       (wb_dat_i & wmask);
      end
    end
  end

  // Exception level sets on any taken exception; software clears it on return
  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      exl_reg <= 1'b0;
    else if (clk_en_i)
    begin
      if (exc_take_i)
        exl_reg <= 1'b1;
      else if (wr_status && wb_sel_i[0])
        exl_reg <= wb_dat_i[`ECR_STATUS_EXL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Timer
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      count_reg <= `ECR_ZERO32;
      compare_reg <= `ECR_ZERO32;
    end
    else if (clk_en_i)
    begin
      if (wr_count)
        count_reg <= (count_reg & ~wmask) | (wb_dat_i & wmask);
      else
        count_reg <= count_reg + 32'h00000001;
      if (wr_compare)
        compare_reg <= (compare_reg & ~wmask) | (wb_dat_i & wmask);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign id_view = {16'h0000, IMP_NUMBER, REV_NUMBER};

  // Read data is registered and held until the next request
  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      wb_dat_o <= `ECR_ZERO32;
    else if (clk_en_i && bus_req && !wb_we_i)
    begin
      case (wb_adr_i)
        `ECR_OFS_CAUSE: wb_dat_o <= cause_view;
        `ECR_OFS_RET_LO: wb_dat_o <= return_address_reg[31:0];
        `ECR_OFS_RET_HI: wb_dat_o <= mode64_i ? return_address_reg[63:32] : `ECR_ZERO32;
        `ECR_OFS_PROC_ID: wb_dat_o <= id_view;
        `ECR_OFS_STATUS: wb_dat_o <= {30'h00000000, exl_reg, 1'b0};
        `ECR_OFS_COUNT: wb_dat_o <= count_reg;
        `ECR_OFS_COMPARE: wb_dat_o <= compare_reg;
        default: wb_dat_o <= `ECR_ZERO32;
      endcase
    end
  end

  // Registered views for the pipeline
  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cause_o <= `ECR_ZERO32;
      return_address_o <= `ECR_ZERO64;
      exception_level_flag_o <= 1'b0;
      sw_int_o <= 2'h0;
    end
    else if (clk_en_i)
    begin
      cause_o <= cause_view;
      return_address_o <= mode64_i ? return_address_reg :
                          {32'h00000000, return_address_reg[31:0]};
      exception_level_flag_o <= exl_reg;
      sw_int_o <= sw_int_reg;
    end
  end

endmodule // ecr_exception_regs

`default_nettype wire

//--- verification/ecr_exception_regs_props.sv
// Concurrent checks on the exception cause and return register block
`timescale 1ns/1ns
`default_nettype none
`include "ecr_regs.vh"
module ecr_exception_regs_props
#(
  parameter logic [7:0] IMP_NUMBER = 8'h5A,
  parameter logic [7:0] REV_NUMBER = 8'h01
)
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic exc_take_i,
  input wire logic [4:0] exc_code_i,
  input wire logic exc_delay_slot_i,
  input wire logic [1:0] exc_cop_num_i,
  input wire logic [63:0] exc_insn_addr_i,
  input wire logic [63:0] exc_branch_addr_i,
  input wire logic [5:0] hw_int_i,
  input wire logic [31:0] cause_o,
  input wire logic [63:0] return_address_o,
  input wire logic exception_level_flag_o
);
  // ----
  // Helper logic
  // ----
  logic [31:0] ret_exp_reg;
  // Delay slot resumes at the branch, so the expected address follows the slot flag
  always_ff @(posedge sys_clk_i)
    ret_exp_reg <= exc_delay_slot_i ? exc_branch_addr_i[31:0] : exc_insn_addr_i[31:0];
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_take;
    exc_take_i;
  endsequence
  // Views lag the commit by two edges: register update, then output copy
  property p_code(lo, hi);
    s_take ##0 (exc_code_i >= lo && exc_code_i <= hi) |-> ##2 cause_o[6:2] == $past(exc_code_i, 2);
  endproperty
  // ----
  // Assertions
  // ----
  chk_code_basic: assert property (p_code(0, 3))
    else $error("code 0-3 not recorded");
  chk_code_faults: assert property (p_code(4, 7))
    else $error("code 4-7 not recorded");
  chk_code_system: assert property (p_code(8, 13))
    else $error("code 8-13 not recorded");
  chk_code_reserved: assert property (s_take ##0 (exc_code_i == 5'h0E || exc_code_i > 5'h0F) |->
    ##2 cause_o[6:2] == 5'h0A) else $error("reserved code produced");
  chk_delay_flag: assert property (s_take |-> ##2 cause_o[31] == $past(exc_delay_slot_i, 2))
    else $error("slot flag wrong");
  chk_cop_number: assert property (s_take ##0 exc_code_i == 5'h0B |->
    ##2 cause_o[29:28] == $past(exc_cop_num_i, 2)) else $error("unit number wrong");
  chk_hw_pending: assert property ($stable(hw_int_i) [*3] |-> cause_o[14:10] == hw_int_i[4:0])
    else $error("pending bits wrong");
  chk_ret_load: assert property (s_take ##0 !exception_level_flag_o |->
    ##2 return_address_o[31:0] == $past(ret_exp_reg)) else $error("return address wrong");
  chk_ret_hold: assert property (s_take ##0 exception_level_flag_o |->
    ##2 return_address_o == $past(return_address_o, 2)) else $error("return address moved");
  chk_level_set: assert property (s_take |-> ##[1:2] exception_level_flag_o)
    else $error("level flag not set");
  chk_id_fixed: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `ECR_OFS_PROC_ID |->
    wb_dat_o == {16'h0000, IMP_NUMBER, REV_NUMBER}) else $error("identification wrong");
endmodule // ecr_exception_regs_props
bind ecr_exception_regs ecr_exception_regs_props #(.IMP_NUMBER(IMP_NUMBER), .REV_NUMBER(REV_NUMBER))
  chk (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .exc_take_i(exc_take_i), .exc_code_i(exc_code_i),
  .exc_delay_slot_i(exc_delay_slot_i), .exc_cop_num_i(exc_cop_num_i),
  .exc_insn_addr_i(exc_insn_addr_i), .exc_branch_addr_i(exc_branch_addr_i), .hw_int_i(hw_int_i),
  .cause_o(cause_o), .return_address_o(return_address_o),
  .exception_level_flag_o(exception_level_flag_o));
`default_nettype wire

//--- verification/ecr_pipe_model.sv
// Pipeline side model: commits exceptions and drives the interrupt lines
`timescale 1ns/1ns
`default_nettype none
module ecr_pipe_model
(
  input wire logic sys_clk_i,
  output logic exc_take_o,
  output logic [4:0] exc_code_o,
  output logic exc_delay_slot_o,
  output logic [1:0] exc_cop_num_o,
  output logic [63:0] exc_insn_addr_o,
  output logic [63:0] exc_branch_addr_o,
  output logic [5:0] hw_int_o
);
  // ----
  // Commit and interrupt drivers
  // ----
  // Quiet lines at time zero
  initial
  begin
    exc_take_o = 1'h0;
    {exc_code_o, exc_delay_slot_o, exc_cop_num_o, hw_int_o} = 14'h0000;
    {exc_insn_addr_o, exc_branch_addr_o} = 128'h0;
  end
  // Waits gap plus one edges, so callers can be prompt or slow, then pulses one commit
  task automatic commit(input logic [4:0] code, input logic ds, input logic [1:0] cop,
    input logic [63:0] pc, input int gap);
    repeat (gap + 1) @(posedge sys_clk_i);
    exc_take_o <= 1'h1;
    exc_code_o <= code;
    exc_delay_slot_o <= ds;
    exc_cop_num_o <= cop;
    exc_insn_addr_o <= pc;
    exc_branch_addr_o <= pc - 64'h4; // Branch sits one word before its slot
    @(posedge sys_clk_i);
    exc_take_o <= 1'h0;
    // Qualifiers mean nothing after the commit; scramble so stale values cannot pass
    exc_code_o <= ~code;
    exc_insn_addr_o <= ~pc;
    exc_branch_addr_o <= pc;
  endtask
  // Interrupt lines change just after an edge
  task automatic drive_int(input logic [5:0] v);
    @(posedge sys_clk_i);
    hw_int_o <= v;
  endtask
endmodule // ecr_pipe_model
`default_nettype wire

//--- verification/ecr_exception_regs_test.sv
// Self-checking bench for the exception cause and return register block
`timescale 1ns/1ns
`default_nettype none
`include "ecr_regs.vh"
module ecr_exception_regs_test;
  // ----
  // Signals and instances
  // ----
  localparam logic [7:0] IMP_VAL = 8'h3C; // Arbitrary value
  localparam logic [7:0] REV_VAL = 8'h07; // Arbitrary value
  typedef struct packed {logic [4:0] code; logic ds; logic [1:0] cop; logic [4:0] exp;} ecr_row_t;
  logic sys_clk_i = 1'h0, rstn_i = 1'h0, clk_en_i = 1'h1, mode64_i = 1'h0;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, ack, err, take, ds, err_seen;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, dat_o, rdata, cnt;
  logic [4:0] code;
  logic [1:0] cop, swi;
  logic [5:0] hw;
  logic [63:0] insn, br;
  int fails = 0, total_checks = 0, cycles = 0;
  ecr_row_t rows [19] = '{
    '{5'h00, 1'h0, 2'h0, 5'h00}, '{5'h01, 1'h1, 2'h0, 5'h01}, '{5'h02, 1'h0, 2'h0, 5'h02},
    '{5'h03, 1'h1, 2'h0, 5'h03}, '{5'h04, 1'h0, 2'h0, 5'h04}, '{5'h05, 1'h1, 2'h0, 5'h05},
    '{5'h06, 1'h0, 2'h0, 5'h06}, '{5'h07, 1'h1, 2'h0, 5'h07}, '{5'h08, 1'h0, 2'h0, 5'h08},
    '{5'h09, 1'h1, 2'h0, 5'h09}, '{5'h0A, 1'h0, 2'h0, 5'h0A}, '{5'h0B, 1'h1, 2'h2, 5'h0B},
    '{5'h0B, 1'h0, 2'h1, 5'h0B}, '{5'h0C, 1'h1, 2'h0, 5'h0C}, '{5'h0D, 1'h0, 2'h0, 5'h0D},
    '{5'h0E, 1'h1, 2'h0, 5'h0A}, '{5'h0F, 1'h0, 2'h0, 5'h0F}, '{5'h10, 1'h1, 2'h0, 5'h0A},
    '{5'h1F, 1'h0, 2'h0, 5'h0A}};
  ecr_exception_regs #(.IMP_NUMBER(IMP_VAL), .REV_NUMBER(REV_VAL)) dut (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
    .exc_take_i(take), .exc_code_i(code), .exc_delay_slot_i(ds), .exc_cop_num_i(cop),
    .exc_insn_addr_i(insn), .exc_branch_addr_i(br), .mode64_i(mode64_i), .hw_int_i(hw),
    .cause_o(), .return_address_o(), .exception_level_flag_o(), .sw_int_o(swi));
  ecr_pipe_model pipe (.sys_clk_i(sys_clk_i), .exc_take_o(take), .exc_code_o(code),
    .exc_delay_slot_o(ds), .exc_cop_num_o(cop), .exc_insn_addr_o(insn),
    .exc_branch_addr_o(br), .hw_int_o(hw));
  // ----
  // Clock, timeout and tasks
  // ----
  // 50 ns period
  always #25 sys_clk_i = ~sys_clk_i;
  // The whole run needs about 460 cycles; a hang is cut off well beyond that
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      end_sim();
    end
  end
  task automatic check(input string n, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Classic single cycle; request held until ack or err is seen at an edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge sys_clk_i); while (ack !== 1'h1 && err !== 1'h1);
    rdata = dat_o;
    err_seen = err;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    rstn_i <= 1'h1;
    wb(1'h0, `ECR_OFS_CAUSE, 32'h0);
    check("reset", rdata & 32'hFFFF7FFF, 32'h0);
    wb(1'h0, `ECR_OFS_COUNT, 32'h0);
    cnt = rdata;
    wb(1'h1, `ECR_OFS_COMPARE, cnt + 32'h28);
    wb(1'h0, `ECR_OFS_CAUSE, 32'h0);
    check("tclr", rdata[15], 1'h0);
    repeat (50) @(posedge sys_clk_i);
    wb(1'h0, `ECR_OFS_CAUSE, 32'h0);
    check("tset", rdata[15], 1'h1);
    wb(1'h1, `ECR_OFS_COMPARE, 32'hFFFF0000);
    wb(1'h1, `ECR_OFS_CAUSE, 32'hFFFFFFFF);
    wb(1'h0, `ECR_OFS_CAUSE, 32'h0);
    check("soft", rdata, 32'h00000300);
    check("swout", swi, 2'h3);
    wb(1'h1, `ECR_OFS_CAUSE, 32'h0);
    wb(1'h0, `ECR_OFS_CAUSE, 32'h0);
    check("softclr", rdata, 32'h0);
    // Every exception code, alternating delay slot, each from a cleared level flag
    foreach (rows[i])
    begin
      wb(1'h1, `ECR_OFS_STATUS, 32'h0);
      pipe.commit(rows[i].code, rows[i].ds, rows[i].cop, 64'h400000 + i * 8, 2 + i % 3);
      wb(1'h0, `ECR_OFS_CAUSE, 32'h0);
      check("code", rdata[6:2], rows[i].exp);
      check("slot", rdata[31], rows[i].ds);
      if (rows[i].code == 5'h0B)
        check("cop", rdata[29:28], rows[i].cop);
      wb(1'h0, `ECR_OFS_RET_LO, 32'h0);
      check("ret", rdata, 32'h400000 + i * 8 - (rows[i].ds ? 4 : 0));
      wb(1'h0, `ECR_OFS_STATUS, 32'h0);
      check("level", rdata[1], 1'h1);
    end
    // Nested exception leaves the return address alone
    pipe.commit(5'h08, 1'h0, 2'h0, 64'h900000, 2);
    wb(1'h0, `ECR_OFS_RET_LO, 32'h0);
    check("hold", rdata, 32'h00400090);
    mode64_i <= 1'h1;
    wb(1'h1, `ECR_OFS_RET_LO, 32'h89ABCDEF);
    wb(1'h1, `ECR_OFS_RET_HI, 32'h01234567);
    wb(1'h0, `ECR_OFS_RET_LO, 32'h0);
    check("retlo", rdata, 32'h89ABCDEF);
    wb(1'h0, `ECR_OFS_RET_HI, 32'h0);
    check("rethi", rdata, 32'h01234567);
    wb(1'h1, `ECR_OFS_STATUS, 32'h0);
    pipe.commit(5'h0C, 1'h0, 2'h0, 64'hCAFE000100001234, 2);
    wb(1'h0, `ECR_OFS_RET_HI, 32'h0);
    check("ret64", rdata, 32'hCAFE0001);
    wb(1'h1, `ECR_OFS_PROC_ID, 32'hFFFFFFFF);
    wb(1'h0, `ECR_OFS_PROC_ID, 32'h0);
    check("ident", rdata, {16'h0000, IMP_VAL, REV_VAL});
    wb(1'h0, 8'h1C, 32'h0);
    check("unmapped", {err_seen, rdata}, 33'h100000000);
    pipe.drive_int(6'h2B);
    repeat (3) @(posedge sys_clk_i);
    wb(1'h0, `ECR_OFS_CAUSE, 32'h0);
    check("hwip", rdata[15:10], 6'h2B);
    end_sim();
  end
endmodule // ecr_exception_regs_test
`default_nettype wire
